// >>> src/arf_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Control write aborts conversion, starts none
// - 8-bit unsigned left: full scale FF:00
// - 8-bit signed left: 7F:00 to 80:00
// - 10-bit unsigned left: full scale FF:C0
// - 10-bit signed left: 7F:C0 to 80:00
// - 10-bit right justified: full scale 03:FF
// - Sign select ignored when justification set
// - 8-bit results always in high byte
// - Conversion clock is bus/((prescaler+1)*2)
// - Conversion takes 28 conversion-clock cycles
module arf_core (
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    // Control register write
    input  wire logic                   i_ctrl_wr,
    input  wire arf_pkg::arf_ctrl_s     i_ctrl,
    // Conversion start and analog result
    input  wire logic                   i_start,
    input  wire logic                   i_continuous,
    input  wire logic [9:0]             i_sample,
    // Status and results
    output arf_pkg::arf_ctrl_s          o_ctrl,
    output logic                        o_busy,
    output logic                        o_sampling,
    output logic                        o_done,
    output arf_pkg::arf_result_s        o_result
);
    arf_pkg::arf_state_e  state_q,  state_d;
    arf_pkg::arf_ctrl_s   ctrl_q,   ctrl_d;
    arf_pkg::arf_result_s result_q, result_d;
    logic [4:0]           cyc_q,    cyc_d;
    logic                 done_q,   done_d;
    logic                 cont_q,   cont_d;
    logic                 tick;
    logic                 restart;
    arf_pkg::arf_result_s fmt;

    // Divider realigns on every control write and every start from idle
    assign restart = i_ctrl_wr || (i_start && state_q == arf_pkg::ARF_IDLE);

    arf_prescaler arf_prescaler_inst (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_restart   (restart),
        .i_prescaler (ctrl_q.conversion_clock_prescaler),
        .o_tick      (tick)
    );

    // Format the raw 10-bit code per resolution, justification and sign
    always_comb begin
        logic [7:0] top;
        top = i_sample[9:2];
        fmt = '0;
        if (ctrl_q.eight_bit_resolution_select) begin
            // Justification has no effect on placement here
            fmt.result_high_byte = top;
            if (!ctrl_q.justification_select && ctrl_q.signed_result_select) begin
                fmt.result_high_byte = top ^ arf_pkg::SIGN_FLIP;
            end
        end else if (ctrl_q.justification_select) begin
            fmt = {6'h00, i_sample};
        end else begin
            fmt = {i_sample, 6'h00};
            if (ctrl_q.signed_result_select) begin
                fmt.result_high_byte = top ^ arf_pkg::SIGN_FLIP;
            end
        end
    end

    // Sequencer next state
    always_comb begin
        state_d  = state_q;
        ctrl_d   = ctrl_q;
        result_d = result_q;
        cyc_d    = cyc_q;
        done_d   = 1'b0;
        cont_d   = cont_q;
        if (i_ctrl_wr) begin
            // Write wins over a simultaneous start; nothing new begins
            ctrl_d  = i_ctrl;
            state_d = arf_pkg::ARF_IDLE;
            cyc_d   = 5'h00;
            cont_d  = 1'b0;
        end else begin
            unique case (state_q)
                arf_pkg::ARF_IDLE: begin
                    if (i_start) begin
                        state_d = arf_pkg::ARF_CONVERT;
                        cyc_d   = 5'h00;
                        cont_d  = i_continuous;
                    end
                end
                arf_pkg::ARF_CONVERT: begin
                    if (tick) begin
                        if (cyc_q == arf_pkg::CONV_CYCLES - 5'h01) begin
                            result_d = fmt;
                            done_d   = 1'b1;
                            cyc_d    = 5'h00;
                            if (!cont_q) begin
                                state_d = arf_pkg::ARF_IDLE;
                            end
                        end else begin
                            cyc_d = cyc_q + 5'h01;
                        end
                    end
                end
                default: begin
                    state_d = arf_pkg::ARF_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q  <= arf_pkg::ARF_IDLE;
            ctrl_q   <= '{1'b0, 1'b0, 1'b0, arf_pkg::PRESCALER_RESET};
            result_q <= '0;
            cyc_q    <= 5'h00;
            done_q   <= 1'b0;
            cont_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            ctrl_q   <= ctrl_d;
            result_q <= result_d;
            cyc_q    <= cyc_d;
            done_q   <= done_d;
            cont_q   <= cont_d;
        end
    end

    assign o_ctrl     = ctrl_q;
    assign o_busy     = (state_q == arf_pkg::ARF_CONVERT);
    assign o_sampling = o_busy && (cyc_q < 5'(arf_pkg::SAMPLE_CYCLES));
    assign o_done     = done_q;
    assign o_result   = result_q;

    // Abort: after a control write the block is idle and no result lands
    property p_abort;
        @(posedge i_clk) disable iff (i_rst)
        i_ctrl_wr |=> !o_busy && !o_done && $stable(o_result);
    endproperty
    a_abort: assert property (p_abort) else $error("control write did not abort");

    property p_idle_hold;
        @(posedge i_clk) disable iff (i_rst)
        (!o_busy && !i_start) |=> !o_busy && $stable(o_result);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("idle block changed state");

    // Count of 28 ticks must elapse before done
    property p_cycles;
        @(posedge i_clk) disable iff (i_rst)
        o_done |-> $past(cyc_q) == arf_pkg::CONV_CYCLES - 5'h01 && cyc_q < arf_pkg::CONV_CYCLES_LIMIT;
    endproperty
    a_cycles: assert property (p_cycles) else $error("conversion length not 28");

    // Independent count of divider ticks in the running conversion
    logic [4:0] ticks_q;
    logic [4:0] ticks_d;

    // Cleared while idle and on each result, so every conversion counts afresh
    always_comb begin
        ticks_d = ticks_q;
        if (!o_busy || o_done) begin
            ticks_d = 5'h00;
        end else if (tick) begin
            ticks_d = ticks_q + 5'h01;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ticks_q <= 5'h00;
        end else begin
            ticks_q <= ticks_d;
        end
    end

    property p_ticks;
        @(posedge i_clk) disable iff (i_rst)
        o_done |-> ticks_q == arf_pkg::CONV_CYCLES && ticks_q < arf_pkg::CONV_CYCLES_LIMIT;
    endproperty
    a_ticks: assert property (p_ticks) else $error("conversion did not take 28 ticks");

    // Sample window covers the first 14 ticks of each conversion
    property p_sample_window;
        @(posedge i_clk) disable iff (i_rst)
        (o_busy && !o_done) |-> o_sampling == (ticks_q < 5'(arf_pkg::SAMPLE_CYCLES));
    endproperty
    a_sample_window: assert property (p_sample_window) else $error("sample window length wrong");

    property p_u8;
        @(posedge i_clk) disable iff (i_rst)
        (o_done && o_ctrl.eight_bit_resolution_select && !o_ctrl.signed_result_select)
            |-> o_result.result_high_byte == $past(i_sample[9:2]) && o_result.result_low_byte == 8'h00;
    endproperty
    a_u8: assert property (p_u8) else $error("8-bit unsigned format wrong");

    property p_s8;
        @(posedge i_clk) disable iff (i_rst)
        (o_done && o_ctrl.eight_bit_resolution_select && !o_ctrl.justification_select
            && o_ctrl.signed_result_select)
            |-> o_result.result_high_byte == ($past(i_sample[9:2]) ^ 8'h80);
    endproperty
    a_s8: assert property (p_s8) else $error("8-bit signed format wrong");

    property p_8high;
        @(posedge i_clk) disable iff (i_rst)
        (o_done && o_ctrl.eight_bit_resolution_select) |-> o_result.result_low_byte == 8'h00;
    endproperty
    a_8high: assert property (p_8high) else $error("8-bit result leaked to low byte");

    // Justified 8-bit results stay unsigned whatever the sign select says
    property p_8just;
        @(posedge i_clk) disable iff (i_rst)
        (o_done && o_ctrl.eight_bit_resolution_select && o_ctrl.justification_select)
            |-> o_result.result_high_byte == $past(i_sample[9:2]);
    endproperty
    a_8just: assert property (p_8just) else $error("8-bit justified result not unsigned");

    property p_u10l;
        @(posedge i_clk) disable iff (i_rst)
        (o_done && !o_ctrl.eight_bit_resolution_select && !o_ctrl.justification_select
            && !o_ctrl.signed_result_select) |-> o_result == {$past(i_sample), 6'h00};
    endproperty
    a_u10l: assert property (p_u10l) else $error("10-bit left format wrong");

    property p_s10l;
        @(posedge i_clk) disable iff (i_rst)
        (o_done && !o_ctrl.eight_bit_resolution_select && !o_ctrl.justification_select
            && o_ctrl.signed_result_select) |-> o_result == ({$past(i_sample), 6'h00} ^ 16'h8000);
    endproperty
    a_s10l: assert property (p_s10l) else $error("10-bit signed format wrong");

    property p_r10;
        @(posedge i_clk) disable iff (i_rst)
        (o_done && !o_ctrl.eight_bit_resolution_select && o_ctrl.justification_select)
            |-> o_result == {6'h00, $past(i_sample)};
    endproperty
    a_r10: assert property (p_r10) else $error("right justified format wrong");

    c_done:     cover property (@(posedge i_clk) disable iff (i_rst) o_done);
    c_abort:    cover property (@(posedge i_clk) disable iff (i_rst) o_busy && i_ctrl_wr);
    c_back2:    cover property (@(posedge i_clk) disable iff (i_rst) o_done ##[1:900] o_done);
    c_signed8:  cover property (@(posedge i_clk) disable iff (i_rst)
        o_done && o_ctrl.eight_bit_resolution_select && o_ctrl.signed_result_select);

endmodule

// >>> src/arf_pkg.sv
package arf_pkg;

    // Control fields as written by software in one control write
    typedef struct packed {
        logic       eight_bit_resolution_select;
        logic       justification_select;
        logic       signed_result_select;
        logic [3:0] conversion_clock_prescaler;
    } arf_ctrl_s;

    // Formatted result register pair
    typedef struct packed {
        logic [7:0] result_high_byte;
        logic [7:0] result_low_byte;
    } arf_result_s;

    localparam logic [3:0]  PRESCALER_RESET     = 4'h0;
    localparam logic [4:0]  CONV_CYCLES         = 5'h1c;  // 28 conversion-clock cycles
    localparam logic [4:0]  CONV_CYCLES_LIMIT   = 5'h1e;  // Never 30 or more
    localparam int          SAMPLE_CYCLES       = 14;
    localparam int          RESULT_WIDTH        = 10;
    localparam logic [7:0]  SIGN_FLIP           = 8'h80;

    // Clock limits software must respect, in kHz
    localparam int          BUS_CLOCK_KHZ       = 40000;
    localparam int          CONV_CLOCK_MAX_KHZ  = 2000;
    localparam int          CONV_CLOCK_MIN_KHZ  = 500;

    typedef enum logic [1:0] {
        ARF_IDLE    = 2'b00,
        ARF_CONVERT = 2'b01
    } arf_state_e;

endpackage

// >>> src/arf_prescaler.sv
`timescale 1ns/1ps
// Divides bus clock by (prescaler+1)*2, emitting one-cycle enable pulses
module arf_prescaler (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Control
    input  wire logic       i_restart,
    input  wire logic [3:0] i_prescaler,
    // Conversion clock enable
    output logic            o_tick
);
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic [4:0] last;
    logic       tick_d;
    logic       tick_q;

    // Divisor minus one: (p+1)*2-1 = 2p+1
    assign last = {i_prescaler, 1'b1};

    // Next count; restart aligns the divider to the new conversion
    always_comb begin
        cnt_d  = cnt_q + 5'h01;
        tick_d = 1'b0;
        if (i_restart) begin
            cnt_d = 5'h00;
        end else if (cnt_q >= last) begin
            cnt_d  = 5'h00;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q  <= 5'h00;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign o_tick = tick_q;

    // Cycles since the last tick; the first tick after a restart only arms the check
    logic [4:0] gap_q;
    logic [4:0] gap_d;
    logic       armed_q;
    logic       armed_d;

    always_comb begin
        gap_d   = gap_q + 5'h01;
        armed_d = armed_q;
        if (i_restart) begin
            gap_d   = 5'h00;
            armed_d = 1'b0;
        end else if (o_tick) begin
            gap_d   = 5'h00;
            armed_d = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            gap_q   <= 5'h00;
            armed_q <= 1'b0;
        end else begin
            gap_q   <= gap_d;
            armed_q <= armed_d;
        end
    end

    // Ticks spaced exactly by the programmed divisor, divide by two included
    property p_tick_period;
        @(posedge i_clk) disable iff (i_rst)
        (o_tick && armed_q && !i_restart) |-> gap_q == last;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("prescaler tick too soon");

    property p_div2;
        @(posedge i_clk) disable iff (i_rst)
        (o_tick && i_prescaler == 4'h0 && !i_restart) ##1 (i_prescaler == 4'h0 && !i_restart)
            |-> ##1 o_tick;
    endproperty
    a_div2: assert property (p_div2) else $error("divide by two period wrong");

endmodule

// >>> verification/arf_analog_model.sv
`timescale 1ns/1ps
// Analog channel stand-in: follows the level only in the sample window
module arf_analog_model (
    // Clock
    input  wire logic       i_clk,
    // Sample window and applied level
    input  wire logic       i_sampling,
    input  wire logic [9:0] i_level,
    // Code seen by the converter
    output logic      [9:0] o_code
);
    // Holds like a sample capacitor, so late level changes must not leak in
    always_ff @(posedge i_clk) begin
        if (i_sampling) begin
            o_code <= i_level;
        end
    end
endmodule

// >>> verification/arf_core_bench.sv
`timescale 1ns/1ps
module arf_core_bench;
    logic                 clk;
    logic                 rst;
    logic                 ctrl_wr;
    logic                 start;
    logic                 cont;
    logic                 busy;
    logic                 samp;
    logic                 done;
    logic [9:0]           level;
    logic [9:0]           code;
    arf_pkg::arf_ctrl_s   ctrl;
    arf_pkg::arf_ctrl_s   ctrl_q;
    arf_pkg::arf_ctrl_s   c;
    arf_pkg::arf_result_s res;
    logic [15:0]          held;
    logic [9:0]           codes [3] = '{10'h3ff, 10'h000, 10'h2a5};
    int                   n_errors = 0;
    int                   compares = 0;
    int                   cyc;
    int                   d;

    arf_core arf_core_inst (.i_clk(clk), .i_rst(rst), .i_ctrl_wr(ctrl_wr), .i_ctrl(ctrl), .i_start(start),
        .i_continuous(cont), .i_sample(code), .o_ctrl(ctrl_q), .o_busy(busy), .o_sampling(samp),
        .o_done(done), .o_result(res));
    arf_analog_model arf_analog_model_inst (.i_clk(clk), .i_sampling(samp), .i_level(level), .o_code(code));

    // 40 MHz bus clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (n_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Expected result word, built independently of the design
    function automatic logic [15:0] fmt(input arf_pkg::arf_ctrl_s f, input logic [9:0] v);
        logic [15:0] r;
        if (f.eight_bit_resolution_select) r = {v[9:2], 8'h00};
        else if (f.justification_select) r = {6'h00, v};
        else r = {v, 6'h00};
        if (!f.justification_select && f.signed_result_select) r[15] = ~r[15];
        return r;
    endfunction

    // One control write, optionally with a start in the same cycle
    task automatic write_ctrl(input arf_pkg::arf_ctrl_s f, input logic with_start);
        @(posedge clk);
        ctrl_wr <= 1'b1;
        ctrl    <= f;
        start   <= with_start;
        @(posedge clk);
        ctrl_wr <= 1'b0;
        start   <= 1'b0;
        #1;
        check({9'h0, ctrl_q}, {9'h0, f});
    endtask

    task automatic start_conv(input logic c_mode);
        @(posedge clk);
        start <= 1'b1;
        cont  <= c_mode;
        @(posedge clk);
        start <= 1'b0;
        #1;
        check({15'h0, samp}, 16'h0001);
    endtask

    // Bounded wait; running out ends the run as a failure
    task automatic wait_done(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 40 * d);
        if (done !== 1'b1) begin
            n_errors++;
            wrap_up();
        end
    endtask

    // Idle check: nothing may start or complete
    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            check({14'h0, busy, done}, 16'h0000);
        end
    endtask

    initial begin
        rst     = 1'b1;
        ctrl_wr = 1'b0;
        start   = 1'b0;
        cont    = 1'b0;
        ctrl    = '0;
        level   = 10'h000;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // Every select combination at full scale, zero and mid code
        d = 20;
        for (int m = 0; m < 8; m++) begin
            for (int v = 0; v < 3; v++) begin
                c = {m[2], m[1], m[0], 4'h9};
                write_ctrl(c, 1'b0);
                level = codes[v];
                start_conv(1'b0);
                wait_done(cyc);
                check(res, fmt(c, codes[v]));
                check(16'(cyc + 1 >= 28 * d && cyc + 1 < 29 * d), 16'h0001);
            end
        end
        // Slowest legal divisor, continuous mode; prescaler 15 keeps 500 kHz+
        c = {3'b000, 4'hf};
        d = 32;
        write_ctrl(c, 1'b0);
        level = 10'h3ff;
        start_conv(1'b1);
        wait_done(cyc);
        check(res, 16'hffc0);
        level = 10'h155;
        wait_done(cyc);
        check(16'(cyc >= 28 * d && cyc <= 28 * d + 2), 16'h0001);
        check(res, fmt(c, 10'h155));
        held = res;
        // Abort mid-conversion with a start in the same write cycle
        repeat (100) @(posedge clk);
        write_ctrl(c, 1'b1);
        quiet(30 * d);
        check(res, held);
        wrap_up();
    end
endmodule
